// File: rtl/hub_attach_suspend_irq_ctrl.sv
`timescale 1ns/100ps
module hub_attach_suspend_irq_ctrl #(
  parameter int unsigned N_SRC        = hub_ctrl_pkg::IRQ_SRC_NUM,
  parameter int unsigned L1_ENTRY_CYC = hub_ctrl_pkg::L1_ENTRY_CYC,
  parameter int unsigned L1_EXIT_CYC  = hub_ctrl_pkg::L1_EXIT_CYC,
  parameter int unsigned L2_ENTRY_CYC = hub_ctrl_pkg::L2_ENTRY_CYC,
  parameter int unsigned L2_EXIT_CYC  = hub_ctrl_pkg::L2_EXIT_CYC
) (
  // clock, reset, enable
  input  wire logic               i_ref_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_clk_en,
  // attach control
  input  wire logic               i_upstream_connect_in,
  input  wire logic               i_master_present,
  input  wire logic               i_attach_done,
  // link power requests from the protocol engine
  input  wire logic               i_req_sleep,
  input  wire logic               i_req_suspend,
  input  wire logic               i_req_resume,
  input  wire logic               i_host_configured,
  input  wire logic               i_suspend_out_en,
  // shared interrupt / wake pin
  input  wire logic               i_irq_pin,
  output logic                    o_irq_pin,
  output logic                    o_irq_pin_oe,
  // interrupt sources and status
  input  wire logic [N_SRC-1:0]   i_irq_cond,
  input  wire logic [N_SRC-1:0]   i_irq_mask,
  input  wire logic [N_SRC-1:0]   i_irq_clear,
  output logic      [N_SRC-1:0]   o_irq_status,
  output logic                    o_int_n,
  // hub state
  output logic                    o_attach,
  output logic                    o_suspend,
  output hub_ctrl_pkg::hub_status_s o_status
);

  localparam int unsigned CW = $clog2(L2_ENTRY_CYC + 1);

  // pin synchronisers; the first stage feeds only the second
  logic [1:0] conn_sync;
  logic [1:0] pin_sync;
  logic       conn_s;
  logic       wake_req;
  logic [1:0] oe_hist;
  assign conn_s = conn_sync[1];

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      conn_sync <= 2'h0;
      pin_sync  <= 2'h3;
      oe_hist   <= 2'h0;
    end else if (i_clk_en) begin
      conn_sync <= {conn_sync[0], i_upstream_connect_in};
      pin_sync  <= {pin_sync[0], i_irq_pin};
      oe_hist   <= {oe_hist[0], o_irq_pin_oe};
    end
  end

  // wake request is low on the pin while we are not pulling it low;
  // the synchroniser still shows our own pull for two edges after release
  always_comb begin
    wake_req = !pin_sync[1] && !o_irq_pin_oe && !(|oe_hist);
  end

  // attach gating
  logic next_attach;
  always_comb begin
    if (i_master_present)
      next_attach = i_attach_done && conn_s;
    else
      next_attach = conn_s;
  end

  // link power state machine with transition timers
  hub_ctrl_pkg::link_state_e state;
  hub_ctrl_pkg::link_state_e next_state;
  logic [CW-1:0]             cnt;
  logic [CW-1:0]             next_cnt;
  logic                      done;
  assign done = (cnt == '0);

  always_comb begin
    next_state = state;
    next_cnt   = done ? cnt : cnt - CW'(1);
    if (!o_attach) begin
      next_state = hub_ctrl_pkg::LINK_L0;
      next_cnt   = '0;
    end else begin
      unique case (state)
        hub_ctrl_pkg::LINK_L0: begin
          if (i_req_suspend) begin
            next_state = hub_ctrl_pkg::LINK_TO_L2;
            next_cnt   = CW'(L2_ENTRY_CYC);
          end else if (i_req_sleep) begin
            next_state = hub_ctrl_pkg::LINK_TO_L1;
            next_cnt   = CW'(L1_ENTRY_CYC);
          end
        end
        hub_ctrl_pkg::LINK_TO_L1: if (done) next_state = hub_ctrl_pkg::LINK_L1;
        hub_ctrl_pkg::LINK_L1: begin
          if (i_req_resume) begin
            next_state = hub_ctrl_pkg::LINK_FROM_L1;
            next_cnt   = CW'(L1_EXIT_CYC);
          end
        end
        hub_ctrl_pkg::LINK_FROM_L1: if (done) next_state = hub_ctrl_pkg::LINK_L0;
        hub_ctrl_pkg::LINK_TO_L2: if (done) next_state = hub_ctrl_pkg::LINK_L2;
        hub_ctrl_pkg::LINK_L2: begin
          if (i_req_resume) begin
            next_state = hub_ctrl_pkg::LINK_FROM_L2;
            next_cnt   = CW'(L2_EXIT_CYC);
          end
        end
        hub_ctrl_pkg::LINK_FROM_L2: if (done) next_state = hub_ctrl_pkg::LINK_L0;
      endcase
    end
  end

  // status outputs; clocks stop only in L2, pll back on wake request
  logic                    suspended;
  logic                    next_suspend;
  hub_ctrl_pkg::hub_status_s next_status;
  assign suspended = (state == hub_ctrl_pkg::LINK_L2);

  always_comb begin
    // selective port suspend has no input here, so it cannot reach the pin
    next_suspend = i_suspend_out_en &&
                   (suspended || !i_host_configured);
    next_status.attached = o_attach;
    next_status.link_pwr = suspended ? 2'h2 :
                           (state == hub_ctrl_pkg::LINK_L1) ? 2'h1 : 2'h0;
    next_status.clk_run  = !suspended;
    next_status.pll_on   = !suspended || wake_req;
  end

  // latched, edge-triggered interrupt status, set wins over clear
  logic [N_SRC-1:0] cond_q;
  logic [N_SRC-1:0] next_irq_status;
  logic             next_int_n;
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_src
      always_comb begin
        if (i_irq_cond[g] && !cond_q[g])
          next_irq_status[g] = 1'b1;
        else if (i_irq_clear[g])
          next_irq_status[g] = 1'b0;
        else
          next_irq_status[g] = o_irq_status[g];
      end
    end
  endgenerate

  always_comb begin
    next_int_n = !(|(next_irq_status & i_irq_mask));
  end

  // all state registers except the pin synchronisers and oe_hist
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state        <= hub_ctrl_pkg::LINK_L0;
      cnt          <= '0;
      o_attach     <= hub_ctrl_pkg::RST_ATTACH;
      o_suspend    <= hub_ctrl_pkg::RST_SUSPEND;
      o_status     <= '0;
      cond_q       <= '0;
      o_irq_status <= '0;
      o_int_n      <= 1'b1;
      o_irq_pin    <= 1'b0;
      o_irq_pin_oe <= 1'b0;
    end else if (i_clk_en) begin
      state        <= next_state;
      cnt          <= next_cnt;
      o_attach     <= next_attach;
      o_suspend    <= next_suspend;
      o_status     <= next_status;
      cond_q       <= i_irq_cond;
      o_irq_status <= next_irq_status;
      o_int_n      <= next_int_n;
      o_irq_pin    <= 1'b0; // open drain: only ever pulls low
      o_irq_pin_oe <= !next_int_n;
    end
  end

  // checks
  attach_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && i_master_present && !i_attach_done |=> !o_attach)
    else $error("attached without done bit");
  attach_free_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && !i_master_present && conn_s |=> o_attach)
    else $error("no attach with connect high");
  suspend_lvl_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && i_suspend_out_en && !i_host_configured |=> o_suspend)
    else $error("suspend low while unconfigured");
  clk_stop_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && state == hub_ctrl_pkg::LINK_L1 |=> o_status.clk_run)
    else $error("clock stopped outside suspend");
  pll_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && wake_req |=> o_status.pll_on)
    else $error("pll off on wake request");
  irq_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && o_irq_status[0] && !i_irq_clear[0] |=> o_irq_status[0])
    else $error("status dropped without clear");
  irq_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && !o_irq_status[0] && cond_q[0] |=> !o_irq_status[0])
    else $error("status set on held condition");
  int_out_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en ##1 $stable(i_irq_mask) |-> o_int_n == !(|(o_irq_status & $past(i_irq_mask))))
    else $error("interrupt output mismatch");
  l1_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && state == hub_ctrl_pkg::LINK_L0 && next_state == hub_ctrl_pkg::LINK_TO_L1
    |=> cnt == CW'(L1_ENTRY_CYC))
    else $error("sleep entry timer wrong");

endmodule : hub_attach_suspend_irq_ctrl

// File: rtl/hub_ctrl_pkg.sv
package hub_ctrl_pkg;

  // number of interrupt event sources
  localparam int unsigned IRQ_SRC_NUM = 4;

  // clock rate in kHz, period 8 ns
  localparam int unsigned CLK_KHZ = 125000;

  // link power transition times as printed
  localparam int unsigned L1_ENTRY_US = 65;
  localparam int unsigned L1_EXIT_US  = 100;
  localparam int unsigned L2_ENTRY_US = 3000;
  localparam int unsigned L2_EXIT_US  = 2000;

  // derived cycle counts, rounded down (approximate figures)
  localparam int unsigned L1_ENTRY_CYC = L1_ENTRY_US * CLK_KHZ / 1000;
  localparam int unsigned L1_EXIT_CYC  = L1_EXIT_US * CLK_KHZ / 1000;
  localparam int unsigned L2_ENTRY_CYC = L2_ENTRY_US * CLK_KHZ / 1000;
  localparam int unsigned L2_EXIT_CYC  = L2_EXIT_US * CLK_KHZ / 1000;

  // reset values
  localparam logic RST_ATTACH  = 1'b0;
  localparam logic RST_SUSPEND = 1'b1;

  // link power states
  typedef enum logic [2:0] {
    LINK_L0,
    LINK_TO_L1,
    LINK_L1,
    LINK_FROM_L1,
    LINK_TO_L2,
    LINK_L2,
    LINK_FROM_L2
  } link_state_e;

  // status seen by the outside
  typedef struct packed {
    logic       attached;
    logic [1:0] link_pwr;
    logic       clk_run;
    logic       pll_on;
  } hub_status_s;

endpackage : hub_ctrl_pkg

// File: testbench/hub_attach_suspend_irq_ctrl_tb.sv
`timescale 1ns/100ps
module hub_attach_suspend_irq_ctrl_tb;
  logic       clk = 1'b0, rst, conn, cfgd, sus_en, clk_en;
  logic       sleep, susp, res;
  logic       mp, ad, wk, pin_o, pin_oe, int_n, att, sus, irq_line;
  logic [3:0] cond, mask, clr, stat;
  hub_ctrl_pkg::hub_status_s st;
  int         fail_count = 0;
  int         n_checks = 0;
  int         cycles = 0;
  // free-running clock, 8 ns
  always #4 clk = ~clk;
  // hang guard; the sequence needs about 145 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  // open-drain pin with pull-up, either party pulls low
  assign irq_line = wk ? 1'b0 : (pin_oe ? pin_o : 1'b1);
  hub_attach_suspend_irq_ctrl #(.L1_ENTRY_CYC(4), .L1_EXIT_CYC(4), .L2_ENTRY_CYC(4),
    .L2_EXIT_CYC(4)) dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en),
    .i_upstream_connect_in(conn), .i_master_present(mp), .i_attach_done(ad),
    .i_req_sleep(sleep), .i_req_suspend(susp), .i_req_resume(res),
    .i_host_configured(cfgd), .i_suspend_out_en(sus_en), .i_irq_pin(irq_line),
    .o_irq_pin(pin_o), .o_irq_pin_oe(pin_oe), .i_irq_cond(cond), .i_irq_mask(mask),
    .i_irq_clear(clr), .o_irq_status(stat), .o_int_n(int_n), .o_attach(att),
    .o_suspend(sus), .o_status(st));
  soc_master_model soc (.i_ref_clk(clk), .o_master_present(mp), .o_attach_done(ad),
    .o_irq_clear(clr), .o_wake_pull(wk));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tend(input string name);
    $display("test %s done", name);
  endtask : tend
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // requests are levels, one cycle wide here
  task automatic req(input int k);
    @(negedge clk);
    {sleep, susp, res} = 3'(1 << k);
    cyc(1);
    {sleep, susp, res} = 3'h0;
    cyc(10);
  endtask : req
  // main sequence; every input except the shared pin (irq_line, a continuous assign) starts from a procedural value
  initial begin
    rst    = 1'b1;
    conn   = 1'b0;
    cfgd   = 1'b0;
    sus_en = 1'b0;
    clk_en = 1'b1;
    {sleep, susp, res} = 3'h0;
    cond   = 4'h0;
    mask   = 4'h0;
    cyc(16);
    rst = 1'b0;
    chk({att, sus, int_n, pin_oe}, 8'h6);
    chk(stat, 8'h0);
    conn = 1'b1;
    cyc(10);
    chk(att, 8'h0);
    soc.setup(1'b1, 1'b1);
    cyc(6);
    chk(att, 8'h1);
    tend("attach_master");
    rst = 1'b1;
    soc.setup(1'b0, 1'b0);
    cyc(16);
    chk({att, sus, int_n, pin_oe}, 8'h6);
    rst = 1'b0;
    cyc(6);
    chk({att, sus}, 8'h2);
    tend("attach_alone");
    sus_en = 1'b1;
    cyc(2);
    chk(sus, 8'h1);
    cfgd = 1'b1;
    cyc(3);
    chk(sus, 8'h0);
    req(2);
    chk({st.link_pwr, st.clk_run, sus}, 8'h6);
    req(0);
    chk({st.link_pwr, st.clk_run, sus}, 8'h2);
    tend("sleep");
    req(1);
    chk({st.link_pwr, st.clk_run, sus}, 8'h9);
    soc.wake(1'b1);
    cyc(6);
    chk(st.pll_on, 8'h1);
    soc.wake(1'b0);
    cyc(6);
    chk(st.pll_on, 8'h0);
    req(0);
    chk({st.link_pwr, sus}, 8'h0);
    tend("suspend");
    mask = 4'h1;
    cond = 4'h3;
    cyc(2);
    chk({stat, int_n, pin_oe}, 8'h0d);
    soc.clear(4'h1);
    cyc(2);
    chk({stat, int_n}, 8'h5);
    cond = 4'h0;
    cyc(2);
    chk({stat, int_n}, 8'h5);
    cond = 4'h1;
    cyc(2);
    chk({stat, int_n}, 8'h6);
    soc.clear(4'h3);
    cyc(4);
    chk({stat, int_n}, 8'h1);
    tend("interrupt");
    // a low enable must hold a new edge back until it returns
    clk_en = 1'b0;
    cond   = 4'h3;
    cyc(3);
    chk({stat, int_n}, 8'h1);
    clk_en = 1'b1;
    cyc(2);
    chk({stat, int_n}, 8'h5);
    chk({st.attached, pin_o, st.pll_on}, 8'h5);
    tend("clock_enable");
    stop_test();
  end
endmodule : hub_attach_suspend_irq_ctrl_tb

// File: testbench/soc_master_model.sv
`timescale 1ns/100ps
module soc_master_model (
  // clock
  input  wire logic       i_ref_clk,
  // master side of the hub
  output logic            o_master_present,
  output logic            o_attach_done,
  output logic [3:0]      o_irq_clear,
  output logic            o_wake_pull
);
  // idle master: present, not yet done
  initial begin
    o_master_present = 1'b1;
    o_attach_done    = 1'b0;
    o_irq_clear      = 4'h0;
    o_wake_pull      = 1'b0;
  end
  // attach gating bits as set after configuration
  task automatic setup(input logic present, input logic done);
    @(negedge i_ref_clk);
    o_master_present = present;
    o_attach_done    = done;
  endtask : setup
  // one-cycle clear, as a serial write would give
  task automatic clear(input logic [3:0] bits);
    @(negedge i_ref_clk);
    o_irq_clear = bits;
    @(negedge i_ref_clk);
    o_irq_clear = 4'h0;
  endtask : clear
  // pull shared pin low; kept short to spare suspend current
  task automatic wake(input logic on);
    @(negedge i_ref_clk);
    o_wake_pull = on;
  endtask : wake
endmodule : soc_master_model
